// ### design/tmbs_scanner.sv
`timescale 1ns/100ps
`default_nettype none
`include "tmbs_map.svh"

module tmbs_scanner
	import tmbs_pkg::*;
#(
	parameter int NUM_X = 8,
	parameter int NUM_Y = 6,
	parameter int DEV_W = 12,
	parameter int THR_W = 8,
	parameter int GAP_CYC = 4,
	parameter int SLOT_UNIT_CYC = 1000,
	parameter int SYNC_TIMEOUT_CYC = `TMBS_SYNC_TIMEOUT_CYC
)
(
	input wire logic CORE_CLK_I,
	input wire logic RESET_I,
	input wire logic CE_I,
	input wire logic [7:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [7:0] RDATA_O,
	input wire logic [NUM_X*NUM_Y-1:0] KEY_ENABLE_I,
	input wire logic [NUM_X*NUM_Y*DEV_W-1:0] KEY_DEV_I,
	input wire logic [NUM_X*NUM_Y*THR_W-1:0] KEY_THR_I,
	input wire logic WAKE_SYNC_I,
	output logic [NUM_X-1:0] X_DRIVE_O,
	output logic [NUM_Y-1:0] Y_SENSE_O,
	output logic SCOPE_TRIG_O,
	output logic [NUM_X*NUM_Y-1:0] KEY_DETECT_O,
	output logic SYNC_ERROR_O,
	output logic SLEEP_O
);

	localparam int NK = NUM_X * NUM_Y;
	localparam int KW = $clog2(NK + 1);
	localparam int XW = $clog2(NUM_X + 1);
	localparam int YW = $clog2(NUM_Y + 1);
	localparam int TW = $clog2(SYNC_TIMEOUT_CYC + 1);

	tmbs_key_cfg_t cfg_r [NK];
	tmbs_glob_cfg_t glob_r;
	logic [3:0] spacing_r;
	logic sync_err_r;
	logic sleep_r;
	logic [7:0] rdata_r;
	logic ws_prev_r;
	logic fall;
	logic [7:0] key_off;
	logic [7:0] det_off;
	logic [63:0] det_pad;

	tmbs_state_t state_r;
	logic [KW-1:0] key_r;
	logic [XW-1:0] xi_r;
	logic [YW-1:0] yi_r;
	logic [5:0] pulse_r;
	logic [7:0] tick_r;
	logic [23:0] slot_r;
	logic [TW-1:0] wait_r;
	logic [NUM_X-1:0] x_drv_r;
	logic [NUM_Y-1:0] y_sen_r;
	logic scope_r;
	logic eval_v_r;
	logic [KW-1:0] eval_k_r;
	logic eval2_v_r;
	logic [KW-1:0] eval2_k_r;
	logic [7:0] dwell_cyc;
	logic [23:0] slot_len;
	logic [5:0] burst_last;
	logic [5:0] burst_last_r;
	logic [7:0] dwell_r;
	logic err_set;
	logic wake;

	logic signed [DEV_W-1:0] dev_r [NK];
	logic [THR_W-1:0] thr_r [NK];
	logic [NK-1:0] det_r;
	logic [NK-1:0] supp;
	logic [NK-1:0] touch;
	logic [2:0] hshift;

	assign fall = ws_prev_r & ~WAKE_SYNC_I;
	assign key_off = ADDR_I - `TMBS_KEY_CFG_BASE;
	assign det_off = ADDR_I - `TMBS_DETECT_BASE;
	assign det_pad = 64'(det_r);
	assign err_set = (state_r == ST_SYNC) && !fall &&
		(wait_r == TW'(SYNC_TIMEOUT_CYC - 1));
	assign wake = (state_r == ST_SLEEP) && fall;
	assign burst_last = {cfg_r[key_r].burst_length, 4'hF};
	assign slot_len = 24'(spacing_r * SLOT_UNIT_CYC);

	// Capture time per pulse
	always_comb
	begin
		case (glob_r.dwell)
			2'h0: dwell_cyc = 8'(`TMBS_DWELL0_CYC);
			2'h1: dwell_cyc = 8'(`TMBS_DWELL1_CYC);
			default: dwell_cyc = 8'(`TMBS_DWELL2_CYC);
		endcase
	end

	// Hysteresis shift: 6.25, 12.5, 25, 50 percent
	always_comb
	begin
		case (glob_r.release_hysteresis)
			4'h0: hshift = 3'h4;
			4'h1: hshift = 3'h3;
			4'h2: hshift = 3'h2;
			default: hshift = 3'h1;
		endcase
	end

	// Configuration writes
	always_ff @(posedge CORE_CLK_I)
	begin
		if (RESET_I)
		begin
			for (int i = 0; i < NK; i++)
				cfg_r[i] <= `TMBS_KEY_CFG_RST;
			glob_r <= `TMBS_GLOB_RST;
			spacing_r <= `TMBS_SPACING_RST;
		end
		else if (CE_I && WR_I)
		begin
			if (key_off < 8'(NK))
				cfg_r[key_off[KW-1:0]] <=
					WDATA_I[7:`TMBS_CFG_FIELD_LSB];
			else if (ADDR_I == `TMBS_GLOB_ADDR)
				glob_r <= WDATA_I[6:0];
			else if (ADDR_I == `TMBS_SPACING_ADDR)
				spacing_r <= WDATA_I[3:0];
		end
	end

	// Sticky sync error, write one to clear, set wins
	always_ff @(posedge CORE_CLK_I)
	begin
		if (RESET_I)
			sync_err_r <= 1'b0;
		else if (CE_I)
		begin
			if (err_set)
				sync_err_r <= 1'b1;
			else if (WR_I && ADDR_I == `TMBS_STATUS_ADDR &&
				WDATA_I[`TMBS_STAT_ERR_BIT])
				sync_err_r <= 1'b0;
		end
	end

	// Sleep request, cleared by wake edge
	always_ff @(posedge CORE_CLK_I)
	begin
		if (RESET_I)
			sleep_r <= 1'b0;
		else if (CE_I)
		begin
			if (WR_I && ADDR_I == `TMBS_CTRL_ADDR)
				sleep_r <= WDATA_I[`TMBS_CTRL_SLEEP_BIT];
			else if (wake)
				sleep_r <= 1'b0;
		end
	end

	// Read data, one cycle after strobe
	always_ff @(posedge CORE_CLK_I)
	begin
		if (RESET_I)
			rdata_r <= 8'h00;
		else if (CE_I)
		begin
			rdata_r <= 8'h00;
			if (RD_I)
			begin
				if (key_off < 8'(NK))
					rdata_r <= {cfg_r[key_off[KW-1:0]], 4'h0};
				else if (ADDR_I == `TMBS_GLOB_ADDR)
					rdata_r <= {1'b0, glob_r};
				else if (ADDR_I == `TMBS_SPACING_ADDR)
					rdata_r <= {4'h0, spacing_r};
				else if (ADDR_I == `TMBS_STATUS_ADDR)
					rdata_r <= {6'h00, sleep_r, sync_err_r};
				else if (ADDR_I == `TMBS_CTRL_ADDR)
					rdata_r <= {7'h00, sleep_r};
				else if (det_off < `TMBS_DETECT_BYTES)
					rdata_r <= det_pad[det_off[2:0]*8 +: 8];
			end
		end
	end

	// Wake/sync pin history
	always_ff @(posedge CORE_CLK_I)
	begin
		if (RESET_I)
			ws_prev_r <= 1'b0;
		else if (CE_I)
			ws_prev_r <= WAKE_SYNC_I;
	end

	// Scan and burst sequencer
	always_ff @(posedge CORE_CLK_I)
	begin
		if (RESET_I)
		begin
			state_r <= ST_SELECT;
			key_r <= '0;
			xi_r <= '0;
			yi_r <= '0;
			pulse_r <= 6'h00;
			tick_r <= 8'h00;
			slot_r <= 24'h000000;
			wait_r <= '0;
			burst_last_r <= 6'h00;
			dwell_r <= 8'h00;
			x_drv_r <= '0;
			y_sen_r <= '0;
			scope_r <= 1'b0;
			eval_v_r <= 1'b0;
			eval_k_r <= '0;
		end
		else if (CE_I)
		begin
			eval_v_r <= 1'b0;
			if (state_r != ST_SELECT)
				slot_r <= slot_r + 24'h000001;
			case (state_r)
				ST_SELECT:
				begin
					if (key_r == KW'(NK))
					begin
						key_r <= '0;
						xi_r <= '0;
						yi_r <= '0;
						wait_r <= '0;
						if (sleep_r)
							state_r <= ST_SLEEP;
						else if (glob_r.mains_lock_enable)
							state_r <= ST_SYNC;
					end
					else if (KEY_ENABLE_I[key_r])
					begin
						y_sen_r <= NUM_Y'(1) << yi_r;
						x_drv_r <= NUM_X'(1) << xi_r;
						scope_r <= cfg_r[key_r].scope_trigger_enable;
						burst_last_r <= burst_last;
						dwell_r <= dwell_cyc;
						pulse_r <= 6'h00;
						tick_r <= 8'h00;
						slot_r <= 24'h000000;
						state_r <= ST_PULSE;
					end
					else
					begin
						key_r <= key_r + KW'(1);
						if (xi_r == XW'(NUM_X - 1))
						begin
							xi_r <= '0;
							yi_r <= yi_r + YW'(1);
						end
						else
							xi_r <= xi_r + XW'(1);
					end
				end
				ST_PULSE:
				begin
					tick_r <= tick_r + 8'h01;
					if (tick_r == dwell_r - 8'h01)
					begin
						x_drv_r <= '0;
						tick_r <= 8'h00;
						state_r <= ST_GAP;
					end
				end
				ST_GAP:
				begin
					tick_r <= tick_r + 8'h01;
					if (tick_r == 8'(GAP_CYC - 1))
					begin
						tick_r <= 8'h00;
						if (pulse_r == burst_last_r)
						begin
							y_sen_r <= '0;
							scope_r <= 1'b0;
							eval_v_r <= 1'b1;
							eval_k_r <= key_r;
							key_r <= key_r + KW'(1);
							if (xi_r == XW'(NUM_X - 1))
							begin
								xi_r <= '0;
								yi_r <= yi_r + YW'(1);
							end
							else
								xi_r <= xi_r + XW'(1);
							state_r <= ST_SLOT;
						end
						else
						begin
							pulse_r <= pulse_r + 6'h01;
							x_drv_r <= NUM_X'(1) << xi_r;
							state_r <= ST_PULSE;
						end
					end
				end
				ST_SLOT:
				begin
					if (spacing_r == 4'h0 ||
						slot_r >= slot_len - 24'h000001)
						state_r <= ST_SELECT;
				end
				ST_SYNC:
				begin
					wait_r <= wait_r + TW'(1);
					if (fall)
						state_r <= ST_SELECT;
					else if (err_set)
						state_r <= ST_SELECT;
				end
				ST_SLEEP:
				begin
					if (fall)
						state_r <= ST_SELECT;
				end
				default:
					state_r <= ST_SELECT;
			endcase
		end
	end

	// Deviation and threshold capture at burst end
	always_ff @(posedge CORE_CLK_I)
	begin
		if (RESET_I)
		begin
			for (int i = 0; i < NK; i++)
			begin
				dev_r[i] <= '0;
				thr_r[i] <= '0;
			end
			eval2_v_r <= 1'b0;
			eval2_k_r <= '0;
		end
		else if (CE_I)
		begin
			eval2_v_r <= eval_v_r;
			eval2_k_r <= eval_k_r;
			if (eval_v_r)
			begin
				dev_r[eval_k_r] <= KEY_DEV_I[eval_k_r*DEV_W +: DEV_W];
				thr_r[eval_k_r] <= KEY_THR_I[eval_k_r*THR_W +: THR_W];
			end
		end
	end

	// Per-key suppression and threshold decision
	for (genvar k = 0; k < NK; k++)
	begin : g_key
		logic signed [DEV_W:0] mag;
		logic signed [DEV_W:0] thr_s;
		logic signed [DEV_W:0] rel_s;
		assign mag = -$signed({dev_r[k][DEV_W-1], dev_r[k]});
		assign thr_s = $signed((DEV_W+1)'({1'b0, thr_r[k]}));
		assign rel_s = thr_s - (thr_s >>> hshift);
		assign touch[k] = det_r[k] ? (mag > rel_s) : (mag >= thr_s);

		always_comb
		begin
			supp[k] = 1'b0;
			for (int j = 0; j < NK; j++)
				if (j != k && cfg_r[j].neighbour_suppress_enable &&
					dev_r[j] < dev_r[k])
					supp[k] = cfg_r[k].neighbour_suppress_enable;
		end
	end

	// Detection state
	always_ff @(posedge CORE_CLK_I)
	begin
		if (RESET_I)
			det_r <= '0;
		else if (CE_I && eval2_v_r)
			det_r[eval2_k_r] <= touch[eval2_k_r] & ~supp[eval2_k_r];
	end

	assign RDATA_O = rdata_r;
	assign X_DRIVE_O = x_drv_r;
	assign Y_SENSE_O = y_sen_r;
	assign SCOPE_TRIG_O = scope_r;
	assign KEY_DETECT_O = det_r;
	assign SYNC_ERROR_O = sync_err_r;
	assign SLEEP_O = sleep_r;

endmodule // tmbs_scanner

`default_nettype wire

// ### inc/tmbs_map.svh
`ifndef TMBS_MAP_SVH
`define TMBS_MAP_SVH

`define TMBS_KEY_CFG_BASE 8'hC0
`define TMBS_GLOB_ADDR 8'hF0
`define TMBS_SPACING_ADDR 8'hF1
`define TMBS_STATUS_ADDR 8'hF8
`define TMBS_CTRL_ADDR 8'hF9
`define TMBS_DETECT_BASE 8'hFA
`define TMBS_DETECT_BYTES 8'h06

`define TMBS_CFG_FIELD_LSB 4
`define TMBS_STAT_ERR_BIT 0
`define TMBS_STAT_SLEEP_BIT 1
`define TMBS_CTRL_SLEEP_BIT 0

`define TMBS_KEY_CFG_RST 4'h2
`define TMBS_GLOB_RST 7'h11
`define TMBS_SPACING_RST 4'h0

`define TMBS_CLK_KHZ 200000
`define TMBS_CLK_PERIOD_PS (1000000000 / `TMBS_CLK_KHZ)
`define TMBS_DWELL0_PS 125000
`define TMBS_DWELL1_PS 187500
`define TMBS_DWELL2_PS 312500
`define TMBS_PS2CYC(p) (((p) + `TMBS_CLK_PERIOD_PS - 1) / `TMBS_CLK_PERIOD_PS)
`define TMBS_DWELL0_CYC `TMBS_PS2CYC(`TMBS_DWELL0_PS)
`define TMBS_DWELL1_CYC `TMBS_PS2CYC(`TMBS_DWELL1_PS)
`define TMBS_DWELL2_CYC `TMBS_PS2CYC(`TMBS_DWELL2_PS)
`define TMBS_SYNC_TIMEOUT_MS 100
`define TMBS_SYNC_TIMEOUT_CYC (`TMBS_SYNC_TIMEOUT_MS * `TMBS_CLK_KHZ)

`endif

// ### inc/tmbs_pkg.sv
package tmbs_pkg;

	typedef enum logic [2:0] {
		ST_SELECT,
		ST_PULSE,
		ST_GAP,
		ST_SLOT,
		ST_SYNC,
		ST_SLEEP
	} tmbs_state_t;

	typedef struct packed {
		logic scope_trigger_enable;
		logic neighbour_suppress_enable;
		logic [1:0] burst_length;
	} tmbs_key_cfg_t;

	typedef struct packed {
		logic mains_lock_enable;
		logic [1:0] dwell;
		logic [3:0] release_hysteresis;
	} tmbs_glob_cfg_t;

endpackage

// ### tb/tmbs_matrix_model.sv
`timescale 1ns/100ps
`default_nettype none
module tmbs_matrix_model #(
	parameter int NK = 48,
	parameter int DW = 12,
	parameter int HALF = 50
)
(
	input wire logic clk_i,
	input wire logic [7:0] x_i,
	input wire logic [5:0] y_i,
	input wire logic [NK*DW-1:0] touch_i,
	input wire logic sync_on_i,
	output logic [NK*DW-1:0] dev_o,
	output logic sync_o
);
	int cnt;
	initial
	begin
		dev_o = '0;
		sync_o = 1'b1;
		cnt = 0;
	end
	// Charge only where driven X meets sensed Y
	always @(posedge clk_i)
	begin
		for (int k = 0; k < NK; k++)
			if (x_i[k % 8] && y_i[k / 8])
				dev_o[k*DW +: DW] <= touch_i[k*DW +: DW];
	end
	// Buffered mains square wave, idle high
	always @(posedge clk_i)
	begin
		cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
		if (!sync_on_i)
			sync_o <= 1'b1;
		else if (cnt == HALF - 1)
			sync_o <= !sync_o;
	end
endmodule // tmbs_matrix_model
`default_nettype wire

// ### tb/tmbs_scanner_bench.sv
`timescale 1ns/100ps
`default_nettype none
module tmbs_scanner_bench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic son = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [47:0] en = 48'h1;
	logic [575:0] tch = '0;
	logic [383:0] thr = {48{8'h14}};
	logic [575:0] dev;
	logic wake, scope, serr, slp, sc;
	logic [7:0] rdata, x, v, np, hi;
	logic [5:0] y;
	logic [47:0] det;
	int mismatches = 0;
	int checks = 0;
	int cyc = 0;
	int n;
	int idle;
	int d0[6] = '{-60, -80, -80, -80, -80, -100};
	int d2[6] = '{-50, -50, -30, -28, -30, -50};
	logic [2:0] ex[6] = '{3'h6, 3'h7, 3'h7, 3'h3, 3'h3, 3'h4};

	always #2.5 clk = ~clk;

	tmbs_scanner #(.SLOT_UNIT_CYC(50), .SYNC_TIMEOUT_CYC(200)) i_dut (
		.CORE_CLK_I(clk), .RESET_I(rst), .CE_I(1'b1), .ADDR_I(addr),
		.WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
		.KEY_ENABLE_I(en), .KEY_DEV_I(dev), .KEY_THR_I(thr),
		.WAKE_SYNC_I(wake), .X_DRIVE_O(x), .Y_SENSE_O(y),
		.SCOPE_TRIG_O(scope), .KEY_DETECT_O(det), .SYNC_ERROR_O(serr),
		.SLEEP_O(slp));
	tmbs_matrix_model i_mx (.clk_i(clk), .x_i(x), .y_i(y), .touch_i(tch),
		.sync_on_i(son), .dev_o(dev), .sync_o(wake));

	task final_report();
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 90000)
		begin
			mismatches++;
			final_report();
		end
	end
	task chk(input string nm, input logic [7:0] e, g);
		checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	function logic [7:0] dwc(input int d);
		int ps;
		ps = (d == 0) ? 125000 : (d == 1) ? 187500 : 312500;
		return 8'((ps + 4999) / 5000);
	endfunction
	task tick();
		@(posedge clk);
		#1;
		n++;
	endtask
	task wr8(input logic [7:0] a, d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rd8(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	task meas(output logic [7:0] pn, ph, output logic pt);
		logic px;
		pn = 8'h00;
		ph = 8'h00;
		pt = 1'b1;
		px = 1'b0;
		n = 0;
		idle = 0;
		tick();
		while (y !== 6'h00 && n < 30000) tick();
		while (y === 6'h00 && n < 30000)
		begin
			idle++;
			tick();
		end
		while (y !== 6'h00 && n < 30000)
		begin
			if (x !== 8'h00 && !px)
				pn++;
			if (x !== 8'h00 && pn == 8'h01)
				ph++;
			pt &= scope;
			px = (x !== 8'h00);
			tick();
		end
	endtask
	task scan();
		n = 0;
		while (x[2] !== 1'b1 && n < 20000) tick();
		while (y !== 6'h00 && n < 20000) tick();
		repeat (3) tick();
	endtask
	task till(input logic s, input logic val);
		n = 0;
		while ((s ? slp : serr) !== val && n < 20000) tick();
	endtask

	initial
	begin
		void'($urandom(29));
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		rd8(8'hC5, v);
		chk("cfg_rst", 8'h20, v);
		rd8(8'hF0, v);
		chk("glob_rst", 8'h11, v);
		rd8(8'hF1, v);
		chk("spacing_rst", 8'h00, v);
		rd8(8'hB0, v);
		chk("unmapped", 8'h00, v);
		for (int i = 0; i < 5; i++)
		begin
			v = 8'($urandom);
			addr <= (i == 4) ? 8'hF0 : 8'hC0 + 8'($urandom % 48);
			@(posedge clk);
			wr8(addr, v);
			rd8(addr, np);
			chk("cfg_rw", v & ((i == 4) ? 8'h7F : 8'hF0), np);
		end
		for (int c = 0; c < 4; c++)
		begin
			wr8(8'hC0, {c[0], 1'b0, c[1:0], 4'h0});
			wr8(8'hF0, {2'b00, 2'(c % 3), 4'h1});
			meas(np, hi, sc);
			chk("pulses", 8'(16 * (c + 1)), np);
			chk("dwell", dwc(c % 3), hi);
			chk("scope", {7'h00, c[0]}, {7'h00, sc});
		end
		en <= 48'h7;
		thr[16 +: 8] <= 8'h20;
		wr8(8'hC0, 8'h40);
		wr8(8'hC1, 8'h40);
		wr8(8'hC2, 8'h00);
		wr8(8'hF0, 8'h01);
		for (int s = 0; s < 6; s++)
		begin
			tch[0 +: 12] <= 12'(d0[s]);
			tch[12 +: 12] <= 12'(-80);
			tch[24 +: 12] <= 12'(d2[s]);
			thr[7:0] <= (s == 5) ? 8'h78 : 8'h14;
			scan();
			scan();
			chk("detect", {5'h00, ex[s]}, {5'h00, det[2:0]});
		end
		rd8(8'hFA, v);
		chk("det_rd", 8'h04, v);
		en <= 48'h1;
		wr8(8'hF1, 8'h0F);
		meas(np, hi, sc);
		meas(np, hi, sc);
		chk("spacing", 8'h01, 8'(idle >= 286 && idle <= 350));
		wr8(8'hF1, 8'h00);
		wr8(8'hF8, 8'h01);
		rd8(8'hF8, v);
		chk("err_pre", 8'h00, v & 8'h01);
		wr8(8'hF0, 8'h41);
		till(1'b0, 1'b1);
		chk("sync_err", 8'h01, {7'h00, serr});
		meas(np, hi, sc);
		chk("scan_on", 8'h10, np);
		chk("sync_wait", 8'h01, 8'(idle >= 200 && idle <= 260));
		son <= 1'b1;
		meas(np, hi, sc);
		wr8(8'hF8, 8'h01);
		meas(np, hi, sc);
		chk("sync_lock", 8'h01, 8'(idle < 200));
		rd8(8'hF8, v);
		chk("err_clear", 8'h00, v & 8'h01);
		wr8(8'hF9, 8'h01);
		till(1'b1, 1'b1);
		chk("sleep", 8'h01, {7'h00, slp});
		till(1'b1, 1'b0);
		chk("wake", 8'h00, {7'h00, slp});
		wr8(8'hF9, 8'h00);
		final_report();
	end
endmodule // tmbs_scanner_bench
`default_nettype wire

// ### tb/tmbs_scanner_sva.sv
`timescale 1ns/100ps
`default_nettype none
module tmbs_scanner_sva #(
	parameter int NUM_X = 8,
	parameter int NUM_Y = 6
)
(
	input wire logic CORE_CLK_I,
	input wire logic RESET_I,
	input wire logic [NUM_X-1:0] X_DRIVE_O,
	input wire logic [NUM_Y-1:0] Y_SENSE_O,
	input wire logic SCOPE_TRIG_O,
	input wire logic SYNC_ERROR_O
);
	logic [6:0] hi_r;
	logic [6:0] np_r;
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (RESET_I);
	// Length of the current X pulse
	always_ff @(posedge CORE_CLK_I)
	begin
		if (RESET_I || X_DRIVE_O == '0)
			hi_r <= 7'h00;
		else
			hi_r <= hi_r + 7'h01;
	end
	// Pulses seen in the current burst
	always_ff @(posedge CORE_CLK_I)
	begin
		if (RESET_I || Y_SENSE_O == '0)
			np_r <= 7'h00;
		else if (X_DRIVE_O != '0 && hi_r == 7'h00)
			np_r <= np_r + 7'h01;
	end
	property p_x_onehot;
		$onehot0(X_DRIVE_O);
	endproperty
	property p_x_with_y;
		X_DRIVE_O != '0 |-> $onehot(Y_SENSE_O);
	endproperty
	property p_y_steady;
		Y_SENSE_O != '0 && $past(Y_SENSE_O) != '0 |-> $stable(Y_SENSE_O);
	endproperty
	property p_scope_in_burst;
		SCOPE_TRIG_O |-> Y_SENSE_O != '0;
	endproperty
	property p_dwell;
		$fell(X_DRIVE_O != '0) |-> hi_r inside {7'h19, 7'h26, 7'h3F};
	endproperty
	property p_gap;
		$fell(X_DRIVE_O != '0) |-> (X_DRIVE_O == '0) [*4]
			##1 (X_DRIVE_O != '0 || Y_SENSE_O == '0);
	endproperty
	property p_pulses;
		$fell(Y_SENSE_O != '0) |-> np_r inside {7'h10, 7'h20, 7'h30, 7'h40};
	endproperty
	property p_err_idle;
		$rose(SYNC_ERROR_O) |-> $past(Y_SENSE_O) == '0;
	endproperty
	a_x_onehot: assert property (p_x_onehot)
		else $error("X drive not one-hot");
	a_x_with_y: assert property (p_x_with_y)
		else $error("X pulse without one Y line");
	a_y_steady: assert property (p_y_steady)
		else $error("Y line changed in burst");
	a_scope_in_burst: assert property (p_scope_in_burst)
		else $error("Scope outside burst");
	a_dwell: assert property (p_dwell)
		else $error("Dwell length wrong");
	a_gap: assert property (p_gap)
		else $error("Pulse spacing wrong");
	a_pulses: assert property (p_pulses)
		else $error("Pulse count wrong");
	a_err_idle: assert property (p_err_idle)
		else $error("Sync error during burst");
	c_scope: cover property ($rose(SCOPE_TRIG_O));
	c_err: cover property ($rose(SYNC_ERROR_O));
	c_long: cover property ($fell(Y_SENSE_O != '0) && np_r == 7'h40);
endmodule // tmbs_scanner_sva
bind tmbs_scanner tmbs_scanner_sva #(.NUM_X(NUM_X), .NUM_Y(NUM_Y)) i_sva (
	.CORE_CLK_I(CORE_CLK_I), .RESET_I(RESET_I), .X_DRIVE_O(X_DRIVE_O),
	.Y_SENSE_O(Y_SENSE_O), .SCOPE_TRIG_O(SCOPE_TRIG_O),
	.SYNC_ERROR_O(SYNC_ERROR_O));
`default_nettype wire
